// File: rtl/cmsf_regs.svh
`ifndef CMSF_REGS_SVH
`define CMSF_REGS_SVH

// register byte offsets on the apb bus
`define CMSF_OFS_LINK_STATE 12'h000
`define CMSF_OFS_CONN_LO 12'h004
`define CMSF_OFS_CONN_HI 12'h008
`define CMSF_OFS_RECONN_LO 12'h00C
`define CMSF_OFS_RECONN_HI 12'h010
`define CMSF_OFS_PA_RX_LO 12'h014
`define CMSF_OFS_PA_RX_HI 12'h018
`define CMSF_OFS_PB_RX_LO 12'h01C
`define CMSF_OFS_PB_RX_HI 12'h020
`define CMSF_OFS_REQ_CTRL 12'h024
`define CMSF_OFS_LINK_MODE_LO 12'h028
`define CMSF_OFS_LINK_MODE_HI 12'h02C
`define CMSF_OFS_LINK_TRBL_LO 12'h030
`define CMSF_OFS_LINK_TRBL_HI 12'h034
`define CMSF_OFS_IRQ_STAT 12'h038
`define CMSF_OFS_IRQ_MASK 12'h03C

// link state word bit positions
`define CMSF_BIT_NORMAL_VS_TEST 15
`define CMSF_BIT_RING_MEMBER 14
`define CMSF_BIT_HOST_IF_FAULT 13
`define CMSF_BIT_SHARED_RAM_SHORT 12
`define CMSF_BIT_MODULE_SYS_FAULT 11

// request control register field positions
`define CMSF_REQ_SOFT_BIT 0
`define CMSF_REQ_OUT_BIT 1
`define CMSF_REQ_INIT_BIT 2
`define CMSF_REQ_TARGET_LSB 8

// target station selector values
`define CMSF_TARGET_MAX_SINGLE 8'h3F
`define CMSF_TARGET_ALL 8'hFF

// interrupt status bits
`define CMSF_IRQ_RECONN 0
`define CMSF_IRQ_PA_RX 1
`define CMSF_IRQ_PB_RX 2
`define CMSF_IRQ_TRBL 3
`define CMSF_IRQ_W 4

// reset values
`define CMSF_RST_MAP 64'h0000_0000_0000_0000
`define CMSF_RST_TARGET 8'h00
`define CMSF_RST_IRQ 4'h0

`endif

// File: rtl/cmsf_pkg.sv
package cmsf_pkg;

    // module state levels feeding the link state word
    typedef struct packed {
        logic normal_vs_test_bit;
        logic ring_member_bit;
        logic host_interface_fault;
        logic shared_ram_short;
        logic module_system_fault;
    } cmsf_link_state_t;

    // one-cycle network events, each carrying a station or setting number
    typedef struct packed {
        logic valid;
        logic [5:0] index;
    } cmsf_event_t;

    // request pulses towards the remote stations
    typedef struct packed {
        logic [63:0] soft_reset;
        logic [63:0] output_reset;
        logic [63:0] link_init;
    } cmsf_remote_req_t;

endpackage : cmsf_pkg

// File: rtl/cmsf_status_flags.sv
// Function
// R1: link state word is one 16-bit status word, state bits in upper positions
// R2: bit 15 high in normal operation, low in test mode
// R3: bit 14 high while module can talk to other ring stations
// R4: bit 13 high when host interface to module has stopped
// R5: bit 12 high when shared RAM is too short for a service
// R6: bit 11 high on module hardware or system software fault
// R7: connected map shows live station state; software writes ignored
// R8: reconnect bit set on reconnection, held; software writes 0 to re-arm
// R9: port A frame bit set on frame, cleared when receive block reads
// R10: port B frame bit set on frame, cleared when receive block reads
// R11: soft reset request goes to stations chosen by target field
// R12: output reset request goes to stations chosen by target field
// R13: station power dip clears its mode bit and sets its trouble bit
// R14: link init request sets mode bits and clears trouble of chosen stations
// R15: target 0 to 63 selects one station, 255 selects all
// R16: other target values are ignored; request bits clear once issued
// R17: maps cleared and requests low after reset
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "cmsf_regs.svh"

module cmsf_status_flags (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // module state levels and live connection map
    input wire cmsf_pkg::cmsf_link_state_t link_state,
    input wire logic [63:0] station_live,
    // network events
    input wire cmsf_pkg::cmsf_event_t reconnect_evt,
    input wire cmsf_pkg::cmsf_event_t port_a_frame_evt,
    input wire cmsf_pkg::cmsf_event_t port_b_frame_evt,
    input wire cmsf_pkg::cmsf_event_t power_dip_evt,
    // receive message block read strobes
    input wire cmsf_pkg::cmsf_event_t port_a_read_evt,
    input wire cmsf_pkg::cmsf_event_t port_b_read_evt,
    // requests to remote stations and interrupt
    output cmsf_pkg::cmsf_remote_req_t remote_req,
    output logic irq
);

    logic [15:0] link_state_word;
    logic [63:0] reconn_r, reconn_nxt;
    logic [63:0] pa_rx_r, pa_rx_nxt;
    logic [63:0] pb_rx_r, pb_rx_nxt;
    logic [63:0] mode_r, mode_nxt;
    logic [63:0] trbl_r, trbl_nxt;
    logic [7:0] target_r, target_nxt;
    logic soft_req_r, soft_req_nxt;
    logic out_req_r, out_req_nxt;
    logic init_req_r, init_req_nxt;
    logic [`CMSF_IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [`CMSF_IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [63:0] sel_mask;
    logic [63:0] wr_word;
    logic wr_en, rd_en;
    logic mapped;

    // state word: upper five bits from the module, lower bits reserved as zero
    always_comb
    begin
        link_state_word = 16'h0000; // R1
        link_state_word[`CMSF_BIT_NORMAL_VS_TEST] = link_state.normal_vs_test_bit; // R2
        link_state_word[`CMSF_BIT_RING_MEMBER] = link_state.ring_member_bit; // R3
        link_state_word[`CMSF_BIT_HOST_IF_FAULT] = link_state.host_interface_fault; // R4
        link_state_word[`CMSF_BIT_SHARED_RAM_SHORT] = link_state.shared_ram_short; // R5
        link_state_word[`CMSF_BIT_MODULE_SYS_FAULT] = link_state.module_system_fault; // R6
    end

    // access phase completes in one cycle; slave never inserts wait states
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // target decode: one station, all stations, or nothing for other values
    always_comb
    begin
        sel_mask = 64'h0000_0000_0000_0000;
        if (target_r <= `CMSF_TARGET_MAX_SINGLE)
        begin
            sel_mask[target_r[5:0]] = 1'b1; // R15
        end
        else if (target_r == `CMSF_TARGET_ALL)
        begin
            sel_mask = 64'hFFFF_FFFF_FFFF_FFFF; // R15
        end
        // any other value leaves the mask empty, so the request does nothing
    end

    // requests drive one-cycle pulses to the selected stations
    always_comb
    begin
        remote_req.soft_reset = soft_req_r ? sel_mask : 64'h0000_0000_0000_0000; // R11
        remote_req.output_reset = out_req_r ? sel_mask : 64'h0000_0000_0000_0000; // R12
        remote_req.link_init = init_req_r ? sel_mask : 64'h0000_0000_0000_0000; // R14
    end

    // address decode of the full map
    always_comb
    begin
        mapped = 1'b1;
        unique case (paddr)
            `CMSF_OFS_LINK_STATE,
            `CMSF_OFS_CONN_LO,
            `CMSF_OFS_CONN_HI,
            `CMSF_OFS_RECONN_LO,
            `CMSF_OFS_RECONN_HI,
            `CMSF_OFS_PA_RX_LO,
            `CMSF_OFS_PA_RX_HI,
            `CMSF_OFS_PB_RX_LO,
            `CMSF_OFS_PB_RX_HI,
            `CMSF_OFS_REQ_CTRL,
            `CMSF_OFS_LINK_MODE_LO,
            `CMSF_OFS_LINK_MODE_HI,
            `CMSF_OFS_LINK_TRBL_LO,
            `CMSF_OFS_LINK_TRBL_HI,
            `CMSF_OFS_IRQ_STAT,
            `CMSF_OFS_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    // write data copied onto both halves; the address picks which half of the 64-bit map uses it
    assign wr_word = {pwdata, pwdata};

    // read data mux, registered so prdata comes from a flip-flop
    always_comb
    begin
        prdata_nxt = prdata_r;
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                `CMSF_OFS_LINK_STATE: prdata_nxt = {16'h0000, link_state_word};
                `CMSF_OFS_CONN_LO: prdata_nxt = station_live[31:0]; // R7
                `CMSF_OFS_CONN_HI: prdata_nxt = station_live[63:32]; // R7
                `CMSF_OFS_RECONN_LO: prdata_nxt = reconn_r[31:0];
                `CMSF_OFS_RECONN_HI: prdata_nxt = reconn_r[63:32];
                `CMSF_OFS_PA_RX_LO: prdata_nxt = pa_rx_r[31:0];
                `CMSF_OFS_PA_RX_HI: prdata_nxt = pa_rx_r[63:32];
                `CMSF_OFS_PB_RX_LO: prdata_nxt = pb_rx_r[31:0];
                `CMSF_OFS_PB_RX_HI: prdata_nxt = pb_rx_r[63:32];
                `CMSF_OFS_REQ_CTRL: prdata_nxt = {16'h0000, target_r, 5'h00,
                                                 init_req_r, out_req_r, soft_req_r};
                `CMSF_OFS_LINK_MODE_LO: prdata_nxt = mode_r[31:0];
                `CMSF_OFS_LINK_MODE_HI: prdata_nxt = mode_r[63:32];
                `CMSF_OFS_LINK_TRBL_LO: prdata_nxt = trbl_r[31:0];
                `CMSF_OFS_LINK_TRBL_HI: prdata_nxt = trbl_r[63:32];
                `CMSF_OFS_IRQ_STAT: prdata_nxt = {28'h0000000, irq_stat_r};
                `CMSF_OFS_IRQ_MASK: prdata_nxt = {28'h0000000, irq_mask_r};
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end
    assign prdata = prdata_r;

    // flag maps: software clears first, then hardware sets so a same-cycle event wins
    always_comb
    begin
        reconn_nxt = reconn_r;
        pa_rx_nxt = pa_rx_r;
        pb_rx_nxt = pb_rx_r;
        // writes to the connected map are simply not decoded
        if (wr_en && paddr == `CMSF_OFS_RECONN_LO)
        begin
            reconn_nxt[31:0] = reconn_r[31:0] & wr_word[31:0]; // R8
        end
        if (wr_en && paddr == `CMSF_OFS_RECONN_HI)
        begin
            reconn_nxt[63:32] = reconn_r[63:32] & wr_word[63:32]; // R8
        end
        if (port_a_read_evt.valid)
        begin
            pa_rx_nxt[port_a_read_evt.index] = 1'b0; // R9
        end
        if (port_b_read_evt.valid)
        begin
            pb_rx_nxt[port_b_read_evt.index] = 1'b0; // R10
        end
        if (reconnect_evt.valid)
        begin
            reconn_nxt[reconnect_evt.index] = 1'b1; // R8
        end
        if (port_a_frame_evt.valid)
        begin
            pa_rx_nxt[port_a_frame_evt.index] = 1'b1; // R9
        end
        if (port_b_frame_evt.valid)
        begin
            pb_rx_nxt[port_b_frame_evt.index] = 1'b1; // R10
        end
    end

    // per-station link mode and trouble; a power dip in the same cycle beats init
    always_comb
    begin
        mode_nxt = mode_r;
        trbl_nxt = trbl_r;
        if (init_req_r)
        begin
            mode_nxt = mode_r | sel_mask; // R14
            trbl_nxt = trbl_r & ~sel_mask; // R14
        end
        if (power_dip_evt.valid)
        begin
            mode_nxt[power_dip_evt.index] = 1'b0; // R13
            trbl_nxt[power_dip_evt.index] = 1'b1; // R13
        end
    end

    // request bits: set by write, self-cleared one cycle after they are issued
    always_comb
    begin
        target_nxt = target_r;
        soft_req_nxt = 1'b0; // R16
        out_req_nxt = 1'b0; // R16
        init_req_nxt = 1'b0; // R16
        if (wr_en && paddr == `CMSF_OFS_REQ_CTRL)
        begin
            // target written with the request takes effect with it
            target_nxt = pwdata[`CMSF_REQ_TARGET_LSB +: 8];
            soft_req_nxt = pwdata[`CMSF_REQ_SOFT_BIT];
            out_req_nxt = pwdata[`CMSF_REQ_OUT_BIT];
            init_req_nxt = pwdata[`CMSF_REQ_INIT_BIT];
        end
    end

    // interrupt status: sticky events, cleared by reading; events win over the clear
    always_comb
    begin
        irq_stat_nxt = irq_stat_r;
        irq_mask_nxt = irq_mask_r;
        if (rd_en && paddr == `CMSF_OFS_IRQ_STAT)
        begin
            // only the bits the read returned, so an event at the setup edge survives
            irq_stat_nxt = irq_stat_r & ~prdata_r[`CMSF_IRQ_W-1:0];
        end
        if (wr_en && paddr == `CMSF_OFS_IRQ_MASK)
        begin
            irq_mask_nxt = pwdata[`CMSF_IRQ_W-1:0];
        end
        if (reconnect_evt.valid)
        begin
            irq_stat_nxt[`CMSF_IRQ_RECONN] = 1'b1;
        end
        if (port_a_frame_evt.valid)
        begin
            irq_stat_nxt[`CMSF_IRQ_PA_RX] = 1'b1;
        end
        if (port_b_frame_evt.valid)
        begin
            irq_stat_nxt[`CMSF_IRQ_PB_RX] = 1'b1;
        end
        if (power_dip_evt.valid)
        begin
            irq_stat_nxt[`CMSF_IRQ_TRBL] = 1'b1;
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // flag map registers; reset clears every station bit
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reconn_r <= `CMSF_RST_MAP; // R17
            pa_rx_r <= `CMSF_RST_MAP; // R17
            pb_rx_r <= `CMSF_RST_MAP; // R17
        end
        else
        begin
            reconn_r <= reconn_nxt;
            pa_rx_r <= pa_rx_nxt;
            pb_rx_r <= pb_rx_nxt;
        end
    end

    // link mode and trouble registers; mode stays off until a link init
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mode_r <= `CMSF_RST_MAP; // R17
            trbl_r <= `CMSF_RST_MAP; // R17
        end
        else
        begin
            mode_r <= mode_nxt;
            trbl_r <= trbl_nxt;
        end
    end

    // request registers; no pulse can leave the block during reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            target_r <= `CMSF_RST_TARGET;
            soft_req_r <= 1'b0; // R17
            out_req_r <= 1'b0; // R17
            init_req_r <= 1'b0; // R17
        end
        else
        begin
            target_r <= target_nxt;
            soft_req_r <= soft_req_nxt;
            out_req_r <= out_req_nxt;
            init_req_r <= init_req_nxt;
        end
    end

    // interrupt status and mask registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq_stat_r <= `CMSF_RST_IRQ;
            irq_mask_r <= `CMSF_RST_IRQ;
        end
        else
        begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // read data register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            prdata_r <= prdata_nxt;
        end
    end

endmodule : cmsf_status_flags

`default_nettype wire

// File: verification/cmsf_status_flags_properties.sv
`timescale 1ns/1ns
`default_nettype none

module cmsf_status_flags_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // state, network and requests
    input wire cmsf_pkg::cmsf_link_state_t link_state,
    input wire logic [63:0] station_live,
    input wire cmsf_pkg::cmsf_event_t reconnect_evt,
    input wire cmsf_pkg::cmsf_event_t power_dip_evt,
    input wire cmsf_pkg::cmsf_remote_req_t remote_req,
    input wire logic irq
);
    logic req_wr;
    logic setup_rd;
    logic [7:0] tgt;

    // request word write and read setup decode
    assign req_wr = psel && penable && pwrite && paddr == 12'h024;
    assign setup_rd = psel && !penable && !pwrite;
    assign tgt = pwdata[15:8];

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_soft_all: assert property (
        req_wr && pwdata[0] && tgt == 8'hFF |=> &remote_req.soft_reset)
        else $error("soft reset missed some stations");
    a_out_single: assert property (
        req_wr && pwdata[1] && tgt < 8'h40
        |=> remote_req.output_reset == 64'h1 << $past(tgt[5:0]))
        else $error("output reset hit wrong station");
    a_init_single: assert property (
        req_wr && pwdata[2] && tgt < 8'h40
        |=> remote_req.link_init == 64'h1 << $past(tgt[5:0]))
        else $error("link init hit wrong station");
    a_bad_target: assert property (
        req_wr && tgt > 8'h3F && tgt != 8'hFF |=> remote_req == '0)
        else $error("request issued for bad target");
    a_pulse_idle: assert property (
        !req_wr |=> remote_req == '0)
        else $error("request pulse without a write");
    a_live_read: assert property (
        setup_rd && paddr == 12'h004 |=> prdata == $past(station_live[31:0]))
        else $error("connected map read wrong");
    a_state_read: assert property (
        setup_rd && paddr == 12'h000 |=> prdata[15:11] == $past(link_state))
        else $error("link state word read wrong");
    a_reset_quiet: assert property (
        $fell(rst) |-> remote_req == '0 && !irq && prdata == '0)
        else $error("outputs not quiet after reset");

    c_reconnect: cover property (reconnect_evt.valid);
    c_dip: cover property (power_dip_evt.valid);
    c_irq: cover property ($rose(irq));
endmodule : cmsf_status_flags_properties

bind cmsf_status_flags cmsf_status_flags_properties cmsf_status_flags_properties_inst (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_state(link_state), .station_live(station_live), .reconnect_evt(reconnect_evt),
    .power_dip_evt(power_dip_evt), .remote_req(remote_req), .irq(irq));

`default_nettype wire

// File: verification/cmsf_remote_model.sv
`timescale 1ns/1ns
`default_nettype none

module cmsf_remote_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // requests in, scoreboard clear
    input wire cmsf_pkg::cmsf_remote_req_t remote_req,
    input wire logic clr,
    // events: reconnect, frame a, frame b, dip, read a, read b
    output var cmsf_pkg::cmsf_event_t evt [6],
    output var cmsf_pkg::cmsf_remote_req_t seen
);
    // keep every request pulse, since a pulse lasts one cycle only
    always @(posedge sys_clk)
        seen <= (rst || clr) ? '0 : seen | remote_req;

    // one-cycle event; index inverted after so a stale number never matches
    task automatic pulse(input int k, input logic [5:0] idx);
        @(posedge sys_clk);
        evt[k] <= {1'b1, idx};
        @(posedge sys_clk);
        evt[k] <= {1'b0, ~idx};
    endtask : pulse

    // quiet network at start
    initial
        for (int i = 0; i < 6; i++)
            evt[i] = '0;
endmodule : cmsf_remote_model

`default_nettype wire

// File: verification/test_comm_module_status_flags.sv
`timescale 1ns/1ns
`default_nettype none

module test_comm_module_status_flags;
    logic sys_clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic clr;
    logic err;
    logic [31:0] q;
    logic [63:0] live;
    logic [63:0] sel;
    logic [7:0] t;
    logic [15:0] rq [4];
    cmsf_pkg::cmsf_link_state_t lst;
    cmsf_pkg::cmsf_remote_req_t rreq;
    cmsf_pkg::cmsf_remote_req_t seen;
    cmsf_pkg::cmsf_event_t ev [6];
    int n_mismatch;
    int n_compared;

    cmsf_status_flags cmsf_status_flags_inst (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_state(lst), .station_live(live), .reconnect_evt(ev[0]),
        .port_a_frame_evt(ev[1]), .port_b_frame_evt(ev[2]), .power_dip_evt(ev[3]),
        .port_a_read_evt(ev[4]), .port_b_read_evt(ev[5]), .remote_req(rreq), .irq(irq));

    cmsf_remote_model cmsf_remote_model_inst (
        .sys_clk(sys_clk), .rst(rst), .remote_req(rreq), .clr(clr), .evt(ev), .seen(seen));

    task automatic chk(input logic [191:0] got, input logic [191:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        apb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask : rd

    task automatic conclude();
        $display("mismatches %0d of %0d compares", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    initial
    begin
        sys_clk = 1'b0;
        forever
            #5 sys_clk = ~sys_clk;
    end

    // a hang ends the run through the same verdict
    initial
    begin
        #100000;
        n_mismatch++;
        conclude();
    end

    initial
    begin
        {rst, clr, lst, live} = {2'b10, 5'h00, 64'h0};
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rq = '{16'h0501, 16'hFF03, 16'h6407, 16'h3F06};
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 12; a < 64; a += 4)
            rd(a[11:0], 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            lst <= 5'h01 << i;
            rd(12'h000, 32'h800 << i, 32'hF800);
        end
        live <= 64'hDEAD_BEEF_0123_4567;
        apb(1'b1, 12'h004, 32'h0);
        chk(err, 1'b0);
        rd(12'h004, 32'h0123_4567);
        rd(12'h008, 32'hDEAD_BEEF);
        // reconnect, masked then unmasked interrupt, write-zero re-arm
        cmsf_remote_model_inst.pulse(0, 6'd40);
        rd(12'h010, 32'h100);
        chk(irq, 1'b0);
        apb(1'b1, 12'h03C, 32'h1);
        @(negedge sys_clk);
        chk(irq, 1'b1);
        rd(12'h038, 32'h1);
        @(negedge sys_clk);
        chk(irq, 1'b0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        rd(12'h010, 32'h100);
        apb(1'b1, 12'h010, 32'hFFFF_FEFF);
        rd(12'h010, 32'h0);
        // frames on both ports, then the receive block reads them
        for (int k = 1; k < 3; k++)
        begin
            cmsf_remote_model_inst.pulse(k, (k == 1) ? 6'd31 : 6'd62);
            rd((k == 1) ? 12'h014 : 12'h020, (k == 1) ? 32'h8000_0000 : 32'h4000_0000);
            cmsf_remote_model_inst.pulse(k + 3, (k == 1) ? 6'd31 : 6'd62);
            rd((k == 1) ? 12'h014 : 12'h020, 32'h0);
        end
        for (int i = 0; i < 4; i++)
        begin
            t = rq[i][15:8];
            sel = (t == 8'hFF) ? '1 : (t < 8'h40) ? 64'h1 << t[5:0] : '0;
            clr <= 1'b1;
            @(posedge sys_clk);
            clr <= 1'b0;
            apb(1'b1, 12'h024, {16'h0, rq[i]});
            rd(12'h024, {16'h0, t, 8'h00}, 32'hFF07);
            chk(seen, {rq[i][0] ? sel : 64'h0, rq[i][1] ? sel : 64'h0, rq[i][2] ? sel : 64'h0});
        end
        // init station 7, power dip, init again
        apb(1'b1, 12'h024, 32'h0704);
        rd(12'h028, 32'h80);
        cmsf_remote_model_inst.pulse(3, 6'd7);
        rd(12'h030, 32'h80);
        rd(12'h028, 32'h0);
        apb(1'b1, 12'h024, 32'h0704);
        rd(12'h028, 32'h80);
        rd(12'h030, 32'h0);
        rd(12'h100, 32'h0);
        chk(err, 1'b1);
        // reset in mid-run with mode bits and interrupt status set
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(12'h028, 32'h0);
        rd(12'h02C, 32'h0);
        rd(12'h038, 32'h0);
        conclude();
    end
endmodule : test_comm_module_status_flags

`default_nettype wire
